// ---- core/hvces_evt_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Carrier between the top and one sticky event register
interface hvces_evt_if;
  logic [15:0] set_vec;
  logic [15:0] w1c_vec;
  logic clr_all;
  logic [15:0] value;
  modport owner (input set_vec, input w1c_vec, input clr_all,
    output value);
  modport user (output set_vec, output w1c_vec, output clr_all,
    input value);
endinterface
`default_nettype wire

// ---- core/hvces_pkg.sv ----
package hvces_pkg;

  // Register select codes on the command port
  localparam logic [1:0] SEL_CHAN_EVT = 2'h0;
  localparam logic [1:0] SEL_MOD_STAT = 2'h1;
  localparam logic [1:0] SEL_MOD_EVT = 2'h3;

  // Channel status and channel event bit positions
  localparam int CH_VLIM = 15;
  localparam int CH_CLIM = 14;
  localparam int CH_TRIP = 13;
  localparam int CH_EINH = 12;
  localparam int CH_VBND = 11;
  localparam int CH_CBND = 10;
  localparam int CH_CV = 7;
  localparam int CH_CC = 6;
  localparam int CH_EMCY = 5;
  localparam int CH_RAMP = 4;
  localparam int CH_ON = 3;
  localparam int CH_IERR = 2;

  // Module status bit positions
  localparam int MS_KILL = 15;
  localparam int MS_TEMP = 14;
  localparam int MS_SPLY = 13;
  localparam int MS_MOD = 12;
  localparam int MS_EVNT = 11;
  localparam int MS_LOOP = 10;
  localparam int MS_NORAMP = 9;
  localparam int MS_NOSERR = 8;
  localparam int MS_SRVC = 4;
  localparam int MS_ADJ = 0;

  // Module event bit positions
  localparam int ME_TEMP = 14;
  localparam int ME_SPLY = 13;
  localparam int ME_LOOP = 10;
  localparam int ME_SRVC = 3;

  // Implemented bits; all others are reserved and read zero
  localparam logic [15:0] CHAN_EVT_MASK = 16'hFCFC;
  localparam logic [15:0] MOD_EVT_MASK = 16'h6408;
  // Channel events that keep high voltage from being switched on
  localparam logic [15:0] CHAN_BLOCK_MASK = 16'hFC20;

  // Reset values
  localparam logic [15:0] EVT_RESET = 16'h0000;
  localparam logic [15:0] STAT_RESET = 16'h0000;

  // Module pin vector layout after synchronisation
  localparam int PIN_TEMP_HIGH = 0;
  localparam int PIN_SUPPLY = 1;
  localparam int PIN_LOOP = 2;
  localparam int PIN_HW_FAIL = 3;
  localparam int PIN_MOD_GOOD = 4;
  localparam int PIN_NO_SERR = 5;
  localparam int PIN_ADJ = 6;
  localparam int PIN_RAMP_ANY = 7;
  localparam int PIN_ISET_EXC = 8;
  localparam int PIN_W = 9;

endpackage

// ---- core/hvces_sticky.sv ----
`timescale 1ns/1ps
`default_nettype none
// Sticky write-one-to-clear event register
module hvces_sticky
  import hvces_pkg::*;
#(
  parameter logic [15:0] VALID = 16'hFFFF
) (
  input wire logic core_clk,
  input wire logic rst,
  hvces_evt_if.owner ev
);
  logic [15:0] val_q;

  // Set beats clear in the same cycle so no event is lost
  always_ff @(posedge core_clk) begin
    if (rst) begin
      val_q <= EVT_RESET;
    end else begin
      val_q <= ((val_q & ~(ev.w1c_vec | {16{ev.clr_all}})) | ev.set_vec)
        & VALID;
    end
  end

  assign ev.value = val_q;
endmodule // hvces_sticky
`default_nettype wire

// ---- core/hvces_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for pin inputs
module hvces_sync #(
  parameter int W = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage is read by the second stage only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule // hvces_sync
`default_nettype wire

// ---- core/hvces_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Channel and module event capture with status word and HV gate
module hvces_top
  import hvces_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] chan_status_pin,
  input wire logic temp_high_pin,
  input wire logic supply_good_pin,
  input wire logic interlock_closed_pin,
  input wire logic hw_failure_pin,
  input wire logic module_good_pin,
  input wire logic no_sum_error_pin,
  input wire logic fine_adjust_pin,
  input wire logic ramp_any_pin,
  input wire logic iset_exceeded_pin,
  input wire logic trip_shutdown_setting,
  input wire logic [15:0] chan_event_mask,
  input wire logic [15:0] mod_event_mask,
  input wire logic hv_on_req,
  input wire logic wr_en,
  input wire logic [1:0] wr_sel,
  input wire logic [15:0] wr_data,
  input wire logic clear_chan_events_cmd,
  input wire logic clear_module_events_cmd,
  input wire logic [1:0] rd_sel,
  output logic [15:0] rd_data,
  output logic hv_enable,
  output logic [15:0] channel_event_capture,
  output logic [15:0] module_status_word,
  output logic [15:0] module_event_capture
);
  logic [15:0] chan_st_s;
  logic [PIN_W-1:0] pin_s;
  logic [PIN_W-1:0] pin_raw;
  logic ramp_prev_q;
  logic on_prev_q;
  logic svc_q;
  logic hv_on_q;
  logic [15:0] mod_stat_q;
  logic [15:0] rd_data_q;
  logic [15:0] chan_set;
  logic [15:0] mod_set;
  logic chan_block;
  logic masked_active;
  logic temp_high_s;
  logic sync_fill_q;
  logic sync_valid_q;

  hvces_evt_if chan_ev ();
  hvces_evt_if mod_ev ();

  // Module pins gathered so one synchroniser serves them all
  assign pin_raw = {iset_exceeded_pin, ramp_any_pin, fine_adjust_pin,
    no_sum_error_pin, module_good_pin, hw_failure_pin,
    interlock_closed_pin, supply_good_pin, temp_high_pin};

  hvces_sync #(.W(16)) u_chan_sync (
    .core_clk(core_clk),
    .rst(rst),
    .din(chan_status_pin),
    .dout(chan_st_s)
  );

  hvces_sync #(.W(PIN_W)) u_pin_sync (
    .core_clk(core_clk),
    .rst(rst),
    .din(pin_raw),
    .dout(pin_s)
  );

  assign temp_high_s = pin_s[PIN_TEMP_HIGH];

  // Synchronisers read zero for two edges after reset; the inverted
  // supply and loop pins would otherwise log events that never happened
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_fill_q <= 1'b0;
      sync_valid_q <= 1'b0;
    end else begin
      sync_fill_q <= 1'b1;
      sync_valid_q <= sync_fill_q;
    end
  end

  // Previous ramp and on levels, for the two edge-type events
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ramp_prev_q <= 1'b0;
      on_prev_q <= 1'b0;
    end else begin
      ramp_prev_q <= chan_st_s[CH_RAMP];
      on_prev_q <= chan_st_s[CH_ON];
    end
  end

  // Level events latch while the live bit is 1, so a bit that was
  // already high at reset release is caught too
  always_comb begin
    chan_set = 16'h0000;
    chan_set[CH_VLIM] = chan_st_s[CH_VLIM];
    chan_set[CH_CLIM] = chan_st_s[CH_CLIM];
    chan_set[CH_TRIP] = chan_st_s[CH_TRIP] | (trip_shutdown_setting &
      (chan_st_s[CH_VLIM] | chan_st_s[CH_CLIM] |
      pin_s[PIN_ISET_EXC]));
    chan_set[CH_EINH] = chan_st_s[CH_EINH];
    chan_set[CH_VBND] = chan_st_s[CH_VBND];
    chan_set[CH_CBND] = chan_st_s[CH_CBND];
    chan_set[CH_CV] = chan_st_s[CH_CV];
    chan_set[CH_CC] = chan_st_s[CH_CC];
    chan_set[CH_EMCY] = chan_st_s[CH_EMCY];
    chan_set[CH_RAMP] = ramp_prev_q & ~chan_st_s[CH_RAMP];
    chan_set[CH_ON] = on_prev_q & ~chan_st_s[CH_ON] &
      ~ramp_prev_q;
    chan_set[CH_IERR] = chan_st_s[CH_IERR];
  end

  // Channel event register: write one clears, command clears all
  assign chan_ev.set_vec = chan_set;
  assign chan_ev.w1c_vec = (wr_en && wr_sel == SEL_CHAN_EVT) ?
    wr_data : 16'h0000;
  assign chan_ev.clr_all = clear_chan_events_cmd;

  hvces_sticky #(.VALID(CHAN_EVT_MASK)) u_chan_evt (
    .core_clk(core_clk),
    .rst(rst),
    .ev(chan_ev)
  );

  // Module events from module conditions
  always_comb begin
    mod_set = 16'h0000;
    mod_set[ME_TEMP] = temp_high_s;
    mod_set[ME_SPLY] = ~pin_s[PIN_SUPPLY];
    mod_set[ME_LOOP] = ~pin_s[PIN_LOOP];
    mod_set[ME_SRVC] = pin_s[PIN_HW_FAIL];
  end

  assign mod_ev.set_vec = sync_valid_q ? mod_set : 16'h0000;
  assign mod_ev.w1c_vec = (wr_en && wr_sel == SEL_MOD_EVT) ?
    wr_data : 16'h0000;
  assign mod_ev.clr_all = clear_module_events_cmd;

  hvces_sticky #(.VALID(MOD_EVT_MASK)) u_mod_evt (
    .core_clk(core_clk),
    .rst(rst),
    .ev(mod_ev)
  );

  // Service latch survives event clears; only reset removes it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      svc_q <= 1'b0;
    end else if (pin_s[PIN_HW_FAIL]) begin
      svc_q <= 1'b1;
    end
  end

  assign chan_block = |(chan_ev.value & CHAN_BLOCK_MASK);
  assign masked_active = (|(chan_ev.value & chan_event_mask)) |
    (|(mod_ev.value & mod_event_mask));

  // HV gate: any blocking event, overtemperature or service drops it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hv_on_q <= 1'b0;
    end else if (chan_block || temp_high_s || svc_q || !sync_valid_q) begin
      hv_on_q <= 1'b0;
    end else begin
      hv_on_q <= hv_on_req;
    end
  end

  // Module status word, rebuilt every cycle from live conditions
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mod_stat_q <= STAT_RESET;
    end else begin
      mod_stat_q <= 16'h0000;
      mod_stat_q[MS_KILL] <= trip_shutdown_setting;
      mod_stat_q[MS_TEMP] <= ~temp_high_s;
      mod_stat_q[MS_SPLY] <= pin_s[PIN_SUPPLY];
      mod_stat_q[MS_MOD] <= pin_s[PIN_MOD_GOOD];
      mod_stat_q[MS_EVNT] <= masked_active;
      mod_stat_q[MS_LOOP] <= pin_s[PIN_LOOP];
      mod_stat_q[MS_NORAMP] <= ~pin_s[PIN_RAMP_ANY];
      mod_stat_q[MS_NOSERR] <= pin_s[PIN_NO_SERR];
      mod_stat_q[MS_SRVC] <= svc_q | pin_s[PIN_HW_FAIL];
      mod_stat_q[MS_ADJ] <= pin_s[PIN_ADJ];
    end
  end

  // Read port; unused select reads zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data_q <= 16'h0000;
    end else begin
      case (rd_sel)
        SEL_CHAN_EVT: rd_data_q <= chan_ev.value;
        SEL_MOD_STAT: rd_data_q <= mod_stat_q;
        SEL_MOD_EVT: rd_data_q <= mod_ev.value;
        default: rd_data_q <= 16'h0000;
      endcase
    end
  end

  assign rd_data = rd_data_q;
  assign hv_enable = hv_on_q;
  assign channel_event_capture = chan_ev.value;
  assign module_status_word = mod_stat_q;
  assign module_event_capture = mod_ev.value;

  // Live limit bit reaches the event register one edge later
  chan_capture_a: assert property (
    @(posedge core_clk) disable iff (rst)
    chan_st_s[CH_VLIM] |=> chan_ev.value[CH_VLIM])
    else $error("voltage limit event not captured");

  // A set event holds while no clear of any kind is seen
  chan_hold_a: assert property (
    @(posedge core_clk) disable iff (rst)
    chan_ev.value[CH_CLIM] && !clear_chan_events_cmd &&
    !(wr_en && wr_sel == SEL_CHAN_EVT && wr_data[CH_CLIM])
    |=> chan_ev.value[CH_CLIM])
    else $error("current limit event cleared itself");

  single_clear_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_en && wr_sel == SEL_CHAN_EVT && wr_data[CH_EINH] &&
    !chan_set[CH_EINH] |=> !chan_ev.value[CH_EINH])
    else $error("write one did not clear inhibit event");

  clear_all_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clear_chan_events_cmd && chan_set == 16'h0000
    |=> chan_ev.value == 16'h0000)
    else $error("clear all left channel events set");

  hv_block_a: assert property (
    @(posedge core_clk) disable iff (rst)
    chan_block |=> !hv_on_q)
    else $error("high voltage on despite blocking event");

  trip_capture_a: assert property (
    @(posedge core_clk) disable iff (rst)
    trip_shutdown_setting && pin_s[PIN_ISET_EXC]
    |=> chan_ev.value[CH_TRIP] ##1 !hv_on_q)
    else $error("trip not captured under kill enable");

  ramp_end_a: assert property (
    @(posedge core_clk) disable iff (rst)
    chan_st_s[CH_RAMP] ##1 !chan_st_s[CH_RAMP]
    |=> chan_ev.value[CH_RAMP])
    else $error("end of ramp not captured");

  overtemp_off_a: assert property (
    @(posedge core_clk) disable iff (rst)
    temp_high_s |=> !hv_on_q && !mod_stat_q[MS_TEMP] &&
    mod_ev.value[ME_TEMP])
    else $error("overtemperature not handled");

  // Flag follows the masked event registers one edge later
  masked_active_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (|(chan_ev.value & chan_event_mask)) ||
    (|(mod_ev.value & mod_event_mask)) |=> mod_stat_q[MS_EVNT])
    else $error("event active flag not raised");

  event_flag_clr_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !(|(chan_ev.value & chan_event_mask)) &&
    !(|(mod_ev.value & mod_event_mask)) |=> !mod_stat_q[MS_EVNT])
    else $error("event active flag raised with no masked event");

  // Unused module status and module event positions must stay zero
  status_reserved_a: assert property (
    @(posedge core_clk) disable iff (rst)
    mod_stat_q[7:5] == 3'h0 && mod_stat_q[3:1] == 3'h0 &&
    (mod_ev.value & ~MOD_EVT_MASK) == 16'h0000)
    else $error("reserved bit set");

  // Until the synchronisers hold real pin levels no module event may log and high voltage stays off
  warmup_gate_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !sync_valid_q |=> mod_ev.value == 16'h0000 && !hv_on_q)
    else $error("event logged before pins were valid");

  kill_status_a: assert property (
    @(posedge core_clk) disable iff (rst)
    trip_shutdown_setting |=> mod_stat_q[MS_KILL])
    else $error("kill enable not shown in status");

  service_lock_a: assert property (
    @(posedge core_clk) disable iff (rst)
    pin_s[PIN_HW_FAIL] |=> svc_q [*3] ##0 !hv_on_q)
    else $error("service lock released");

  mod_clear_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clear_module_events_cmd && mod_set == 16'h0000
    |=> mod_ev.value == 16'h0000)
    else $error("module clear left events set");

endmodule // hvces_top
`default_nettype wire

// ---- dv/hvces_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// Directed bench for the event capture block, ports driven on falling edges
module testbench
  import hvces_pkg::*;
;
  logic core_clk, rst, temp_high_pin, supply_good_pin, interlock_closed_pin;
  logic hw_failure_pin, module_good_pin, no_sum_error_pin, fine_adjust_pin;
  logic ramp_any_pin, iset_exceeded_pin, trip_shutdown_setting, hv_on_req;
  logic wr_en, clear_chan_events_cmd, clear_module_events_cmd, hv_enable;
  logic [15:0] chan_status_pin, chan_event_mask, mod_event_mask, wr_data;
  logic [15:0] rd_data, channel_event_capture, module_status_word;
  logic [15:0] module_event_capture;
  logic [1:0] wr_sel, rd_sel;
  int n_fail;
  int compares;

  hvces_top dut (.core_clk(core_clk), .rst(rst),
    .chan_status_pin(chan_status_pin), .temp_high_pin(temp_high_pin),
    .supply_good_pin(supply_good_pin),
    .interlock_closed_pin(interlock_closed_pin),
    .hw_failure_pin(hw_failure_pin), .module_good_pin(module_good_pin),
    .no_sum_error_pin(no_sum_error_pin), .fine_adjust_pin(fine_adjust_pin),
    .ramp_any_pin(ramp_any_pin), .iset_exceeded_pin(iset_exceeded_pin),
    .trip_shutdown_setting(trip_shutdown_setting),
    .chan_event_mask(chan_event_mask), .mod_event_mask(mod_event_mask),
    .hv_on_req(hv_on_req), .wr_en(wr_en), .wr_sel(wr_sel),
    .wr_data(wr_data), .clear_chan_events_cmd(clear_chan_events_cmd),
    .clear_module_events_cmd(clear_module_events_cmd), .rd_sel(rd_sel),
    .rd_data(rd_data), .hv_enable(hv_enable),
    .channel_event_capture(channel_event_capture),
    .module_status_word(module_status_word),
    .module_event_capture(module_event_capture));

  // 20 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Six cycles covers the two-flop sync plus the capture register
  task automatic settle();
    cyc(6);
  endtask

  function automatic logic [15:0] hv16();
    return {15'h0000, hv_enable};
  endfunction

  // One-cycle write strobe, then one idle cycle so strobes never abut
  task automatic wr(input logic [1:0] sel, input logic [15:0] d);
    wr_sel = sel;
    wr_data = d;
    wr_en = 1'b1;
    cyc(1);
    wr_en = 1'b0;
    cyc(1);
  endtask

  task automatic clr_cmd(input logic chan);
    if (chan) clear_chan_events_cmd = 1'b1;
    else clear_module_events_cmd = 1'b1;
    cyc(1);
    clear_chan_events_cmd = 1'b0;
    clear_module_events_cmd = 1'b0;
    cyc(1);
  endtask

  task automatic t_chan_sticky();
    chan_status_pin = 16'h1000;
    settle();
    chk(channel_event_capture, 16'h1000);
    chk(rd_data, 16'h1000);
    chan_status_pin = 16'h0000;
    settle();
    chk(channel_event_capture, 16'h1000);
    chk(hv16(), 16'h0000);
    wr(SEL_CHAN_EVT, 16'h0000);
    chk(channel_event_capture, 16'h1000);
    wr(SEL_MOD_STAT, 16'h1000);
    chk(channel_event_capture, 16'h1000);
    wr(SEL_CHAN_EVT, 16'h1000);
    chk(channel_event_capture, 16'h0000);
    cyc(1);
    chk(hv16(), 16'h0001);
    hv_on_req = 1'b0;
    cyc(2);
    chk(hv16(), 16'h0000);
    hv_on_req = 1'b1;
  endtask

  // Every blocking event alone, then all levels at once
  task automatic t_chan_levels();
    int blk[7] = '{15, 14, 13, 12, 11, 10, 5};
    foreach (blk[i]) begin
      chan_status_pin = 16'h0001 << blk[i];
      settle();
      chk(hv16(), 16'h0000);
      chan_status_pin = 16'h0000;
      settle();
      wr(SEL_CHAN_EVT, 16'h0001 << blk[i]);
      cyc(1);
      chk(hv16(), 16'h0001);
    end
    chan_status_pin = 16'hFFFF;
    settle();
    chk(channel_event_capture, 16'hFCE4);
    chan_status_pin = 16'h0000;
    settle();
    chk(channel_event_capture, 16'hFCF4);
    clr_cmd(1'b1);
    chk(channel_event_capture, 16'h0000);
  endtask

  task automatic t_chan_edges();
    chan_status_pin = 16'h0008;
    settle();
    chan_status_pin = 16'h0000;
    settle();
    chk(channel_event_capture, 16'h0008);
    chan_status_pin = 16'h0010;
    wr(SEL_CHAN_EVT, 16'h0008);
    settle();
    chk(channel_event_capture, 16'h0000);
    chan_status_pin = 16'h0000;
    settle();
    chk(channel_event_capture, 16'h0010);
    iset_exceeded_pin = 1'b1;
    wr(SEL_CHAN_EVT, 16'h0010);
    settle();
    chk(channel_event_capture, 16'h0000);
    trip_shutdown_setting = 1'b1;
    settle();
    chk(channel_event_capture, 16'h2000);
    chk(module_status_word, 16'hF700);
    iset_exceeded_pin = 1'b0;
    trip_shutdown_setting = 1'b0;
    wr(SEL_CHAN_EVT, 16'h2000);
    chk(channel_event_capture, 16'h0000);
  endtask

  task automatic t_status();
    settle();
    chk(module_status_word, 16'h7700);
    ramp_any_pin = 1'b1;
    settle();
    chk(module_status_word, 16'h7500);
    ramp_any_pin = 1'b0;
    module_good_pin = 1'b0;
    fine_adjust_pin = 1'b1;
    settle();
    chk(module_status_word, 16'h6701);
    module_good_pin = 1'b1;
    fine_adjust_pin = 1'b0;
    chan_event_mask = 16'h1000;
    chan_status_pin = 16'h1000;
    settle();
    chk(module_status_word, 16'h7F00);
    chan_status_pin = 16'h0000;
    settle();
    wr(SEL_CHAN_EVT, 16'h1000);
    chk(module_status_word, 16'h7700);
    chan_event_mask = 16'h0000;
  endtask

  task automatic t_mod_events();
    supply_good_pin = 1'b0;
    settle();
    chk(module_status_word, 16'h5700);
    supply_good_pin = 1'b1;
    settle();
    chk(module_event_capture, 16'h2000);
    wr(SEL_MOD_EVT, 16'h2000);
    chk(module_event_capture, 16'h0000);
    interlock_closed_pin = 1'b0;
    settle();
    chk(module_status_word, 16'h7300);
    interlock_closed_pin = 1'b1;
    temp_high_pin = 1'b1;
    settle();
    chk(module_status_word, 16'h3700);
    chk(hv16(), 16'h0000);
    temp_high_pin = 1'b0;
    settle();
    chk(module_event_capture, 16'h4400);
    mod_event_mask = 16'h0400;
    rd_sel = SEL_MOD_STAT;
    cyc(2);
    chk(rd_data, 16'h7F00);
    mod_event_mask = 16'h0000;
    rd_sel = SEL_MOD_EVT;
    cyc(2);
    chk(rd_data, 16'h4400);
    rd_sel = 2'h2;
    cyc(2);
    chk(rd_data, 16'h0000);
    clr_cmd(1'b0);
    chk(module_event_capture, 16'h0000);
    chk(hv16(), 16'h0001);
  endtask

  // Hardware failure is last: it disables high voltage until reset
  task automatic t_hw_fail();
    hw_failure_pin = 1'b1;
    settle();
    chk(module_event_capture, 16'h0008);
    chk(module_status_word, 16'h7710);
    hw_failure_pin = 1'b0;
    settle();
    wr(SEL_MOD_EVT, 16'h0008);
    settle();
    chk(module_event_capture, 16'h0000);
    chk(hv16(), 16'h0000);
  endtask

  task automatic tally_and_finish();
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    cyc(20000);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    n_fail = 0;
    compares = 0;
    {temp_high_pin, hw_failure_pin, fine_adjust_pin, ramp_any_pin} = 4'h0;
    {supply_good_pin, interlock_closed_pin} = 2'h3;
    {module_good_pin, no_sum_error_pin} = 2'h3;
    {iset_exceeded_pin, trip_shutdown_setting, wr_en} = 3'h0;
    {clear_chan_events_cmd, clear_module_events_cmd} = 2'h0;
    chan_status_pin = 16'h0000;
    chan_event_mask = 16'h0000;
    mod_event_mask = 16'h0000;
    wr_data = 16'h0000;
    wr_sel = 2'h0;
    rd_sel = 2'h0;
    hv_on_req = 1'b1;
    rst = 1'b1;
    cyc(5);
    chk(module_event_capture | channel_event_capture | hv16(), 16'h0000);
    rst = 1'b0;
    cyc(2);
    chk(hv16(), 16'h0000);
    cyc(4);
    // Pins are not valid right after reset, so no module event may log
    chk(module_event_capture, 16'h0000);
    wr(SEL_MOD_EVT, 16'hFFFF);
    chk(module_event_capture, 16'h0000);
    t_chan_sticky();
    t_chan_levels();
    t_chan_edges();
    t_status();
    t_mod_events();
    t_hw_fail();
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
